// ==== inc/srz_defines.vh ====
`ifndef SRZ_DEFINES_VH
`define SRZ_DEFINES_VH

// register byte offsets inside the 4 KB window (bit 11 clear)
`define SRZ_OFF_CTRL 12'h000
`define SRZ_OFF_PT_START 12'h004
`define SRZ_OFF_CT_START 12'h008
`define SRZ_OFF_LENGTH 12'h00c
`define SRZ_OFF_ERR_STAT 12'h010
`define SRZ_OFF_IV0 12'h014
`define SRZ_OFF_IV1 12'h018
`define SRZ_OFF_ZCTL 12'h01c
`define SRZ_OFF_STATUS 12'h020
`define SRZ_OFF_INT_STAT 12'h024
`define SRZ_OFF_INT_MASK 12'h028
`define SRZ_OFF_TMR_LOAD 12'h02c
`define SRZ_OFF_TMR_COUNT 12'h030
`define SRZ_OFF_DBG_STAT 12'h034

// secure memory window: byte addresses with bit 11 set
`define SRZ_MEM_SEL_BIT 11

// control register fields
`define SRZ_CTRL_START_BIT 0
`define SRZ_CTRL_DECRYPT_BIT 1

// zeroize control field
`define SRZ_ZCTL_ZERO_BIT 0

// error status fields
`define SRZ_ERR_TMR_BIT 0
`define SRZ_ERR_START_BIT 1

// interrupt status and mask fields
`define SRZ_INT_ZDONE_BIT 0
`define SRZ_INT_CIPH_BIT 1
`define SRZ_INT_TMR_BIT 2
`define SRZ_INT_DBG_BIT 3
`define SRZ_INT_W 4

// reset values
`define SRZ_RST_WORD 32'h0000_0000
`define SRZ_RST_INT 4'h0

`endif

// ==== rtl/srz_sec_timer.v ====
`timescale 1ns/10ps
`include "srz_defines.vh"

// programmable down-counting watchdog of the security monitor
module srz_sec_timer #(
	parameter TW = 32
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire load_in,
	input wire [TW-1:0] load_val_in,
	output reg [TW-1:0] count_out,
	output reg expired_out
);

	reg running_q; // counting while set

	////////////////////////////////////////////////////////////////////////
	// count down; a reload is the service that keeps it from expiring
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			count_out <= {TW{1'b0}};
			running_q <= 1'b0;
			expired_out <= 1'b0;
		end else begin
			expired_out <= 1'b0;
			if (load_in) begin
				count_out <= load_val_in;
				running_q <= (load_val_in != {TW{1'b0}});
			end else if (running_q) begin
				count_out <= count_out - {{(TW-1){1'b0}}, 1'b1};
				if (count_out == {{(TW-1){1'b0}}, 1'b1}) begin
					// reached zero unserviced: one-cycle expiry pulse
					running_q <= 1'b0;
					expired_out <= 1'b1;
				end
			end
		end
	end

endmodule

// ==== rtl/srz_top.v ====
`timescale 1ns/10ps
`include "srz_defines.vh"

// Functional notes
// - zeroizing gives memory to zero controller only
// - ciphering gives memory to encryption unit only
// - host memory access only in idle state
// - zeroize-done low holds cipher and controller reset
// - host accesses ignored while zeroize-done low
// - zeroize by pin or bit, clears both regions
// - zeroize clears address, length, control, error, IVs
// - security violation starts zeroize automatically
// - secret key when secure, default key otherwise
// - secret key never reaches any bus
// - two kilobytes of secure memory
// - 32-bit programmable down-counting security timer
// - timer expiry flags error to security monitor
// - debug alert output and readable debug status
module srz_top #(
	parameter MEM_WORDS = 512, // 2 KB of 32-bit words
	parameter AW = 9, // word index width, at most 9
	parameter DBG_W = 4, // number of debug and scan signals
	parameter [31:0] DEFAULT_KEY = 32'h5a5a_a5a5 // arbitrary test key
) (
	input wire SYS_CLK_IN,
	input wire RST_N_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	output reg [31:0] PRDATA_OUT,
	output reg PREADY_OUT,
	output reg PSLVERR_OUT,
	input wire ZEROIZE_IN,
	input wire VIOLATION_IN,
	input wire SECURE_IN,
	input wire [31:0] SECRET_KEY_IN,
	input wire [DBG_W-1:0] DEBUG_IN,
	output reg IRQ_OUT,
	output reg ZDONE_OUT,
	output reg DBG_ALERT_OUT,
	output reg TMR_ERR_OUT
);

	// access multiplexer owner states
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_ZERO = 2'd1;
	localparam [1:0] ST_CIPH = 2'd2;

	reg [31:0] mem_q [0:MEM_WORDS-1]; // secure red and black storage
	reg [1:0] state_q; // current owner of the memory
	reg zdone_q; // zeroize complete indication
	reg [AW-1:0] zero_idx_q; // next word to clear
	reg [31:0] ctrl_q; // control: decrypt direction
	reg [31:0] pt_start_q; // plaintext start word index
	reg [31:0] ct_start_q; // ciphertext start word index
	reg [31:0] length_q; // words to process
	reg [31:0] err_q; // error status
	reg [31:0] iv0_q; // chaining seed
	reg [31:0] iv1_q; // key whitening word
	reg [`SRZ_INT_W-1:0] int_stat_q; // sticky events
	reg [`SRZ_INT_W-1:0] int_mask_q; // event enables
	reg [AW-1:0] src_idx_q; // cipher read pointer
	reg [AW-1:0] dst_idx_q; // cipher write pointer
	reg [31:0] left_q; // cipher words remaining
	reg [31:0] chain_q; // chaining word
	reg dir_q; // 1 while decrypting
	reg [DBG_W-1:0] dbg_q; // debug signals seen last cycle
	reg [31:0] rd_d; // read data for next answer
	reg err_d; // slave error for next answer
	wire [31:0] tmr_count; // timer value for count register reads
	wire tmr_expired; // timer expiry pulse

	////////////////////////////////////////////////////////////////////////
	// decode of the bus transfer
	wire setup = PSEL_IN & ~PENABLE_IN; // setup phase
	wire done = PSEL_IN & PENABLE_IN & PREADY_OUT; // access phase completes
	wire host_ok = zdone_q; // no effect at all while low
	wire wr = done & PWRITE_IN & host_ok; // accepted write
	wire is_mem = PADDR_IN[`SRZ_MEM_SEL_BIT]; // memory window
	wire [AW-1:0] host_idx = PADDR_IN[AW+1:2]; // host word index
	wire [11:0] roff = {PADDR_IN[11:2], 2'b00}; // aligned register offset
	wire wr_reg = wr & ~is_mem; // register write
	wire wr_mem = wr & is_mem & (state_q == ST_IDLE);

	// zeroize sources: pin, violation and software bit
	wire zero_req = ZEROIZE_IN | VIOLATION_IN
		| (wr_reg & (roff == `SRZ_OFF_ZCTL) & PWDATA_IN[`SRZ_ZCTL_ZERO_BIT]);

	// cipher start: only from idle with work to do
	wire start_wr = wr_reg & (roff == `SRZ_OFF_CTRL) & PWDATA_IN[`SRZ_CTRL_START_BIT];
	wire start_ok = start_wr & (state_q == ST_IDLE) & (length_q != 32'h0000_0000) & ~zero_req;
	wire start_bad = start_wr & ~start_ok & ~zero_req;

	////////////////////////////////////////////////////////////////////////
	// key multiplexer; the chosen key feeds only the cipher datapath
	wire [31:0] key = SECURE_IN ? SECRET_KEY_IN : DEFAULT_KEY;
	wire [31:0] src_word = mem_q[src_idx_q]; // word entering the cipher
	wire [31:0] ciph_out = src_word ^ key ^ iv1_q ^ chain_q;
	// chaining always follows the ciphertext side so decrypt inverts encrypt
	wire [31:0] chain_nx = dir_q ? src_word : ciph_out;
	wire last_word = (left_q == 32'h0000_0001);
	wire zero_last = (zero_idx_q == MEM_WORDS[AW-1:0] - {{(AW-1){1'b0}}, 1'b1});

	////////////////////////////////////////////////////////////////////////
	// owner state machine and zeroize sequencing; a zeroize request wins
	// over a running cipher, which is abandoned mid-block
	always @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			// memory content is unknown at power-up, so reset clears it
			state_q <= ST_ZERO;
			zdone_q <= 1'b0;
			zero_idx_q <= {AW{1'b0}};
		end else if (zero_req) begin
			state_q <= ST_ZERO;
			zdone_q <= 1'b0;
			zero_idx_q <= {AW{1'b0}};
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_ok) begin
						state_q <= ST_CIPH;
					end
				end
				ST_ZERO: begin
					zero_idx_q <= zero_idx_q + {{(AW-1){1'b0}}, 1'b1};
					if (zero_last) begin
						state_q <= ST_IDLE;
						zdone_q <= 1'b1;
					end
				end
				ST_CIPH: begin
					if (last_word) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// the single write port of the memory, steered by the owner
	always @(posedge SYS_CLK_IN) begin
		case (state_q)
			ST_ZERO: begin
				mem_q[zero_idx_q] <= 32'h0000_0000;
			end
			ST_CIPH: begin
				if (zdone_q) begin
					mem_q[dst_idx_q] <= ciph_out;
				end
			end
			default: begin
				if (wr_mem) begin
					mem_q[host_idx] <= PWDATA_IN;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// cipher pointers; held in reset while zeroize-done is low
	always @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN || !zdone_q || zero_req) begin
			src_idx_q <= {AW{1'b0}};
			dst_idx_q <= {AW{1'b0}};
			left_q <= 32'h0000_0000;
			chain_q <= 32'h0000_0000;
			dir_q <= 1'b0;
		end else if (start_ok) begin
			// decrypt reads ciphertext and writes plaintext
			dir_q <= PWDATA_IN[`SRZ_CTRL_DECRYPT_BIT];
			src_idx_q <= PWDATA_IN[`SRZ_CTRL_DECRYPT_BIT] ? ct_start_q[AW-1:0] : pt_start_q[AW-1:0];
			dst_idx_q <= PWDATA_IN[`SRZ_CTRL_DECRYPT_BIT] ? pt_start_q[AW-1:0] : ct_start_q[AW-1:0];
			left_q <= length_q;
			chain_q <= iv0_q;
		end else if (state_q == ST_CIPH) begin
			// one word per cycle; indices wrap inside the memory
			src_idx_q <= src_idx_q + {{(AW-1){1'b0}}, 1'b1};
			dst_idx_q <= dst_idx_q + {{(AW-1){1'b0}}, 1'b1};
			left_q <= left_q - 32'h0000_0001;
			chain_q <= chain_nx;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers; zeroize clears the cipher setup
	always @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN || zero_req) begin
			ctrl_q <= `SRZ_RST_WORD;
			pt_start_q <= `SRZ_RST_WORD;
			ct_start_q <= `SRZ_RST_WORD;
			length_q <= `SRZ_RST_WORD;
			err_q <= `SRZ_RST_WORD;
			iv0_q <= `SRZ_RST_WORD;
			iv1_q <= `SRZ_RST_WORD;
		end else begin
			if (start_ok) begin
				ctrl_q <= {30'h0, PWDATA_IN[`SRZ_CTRL_DECRYPT_BIT], 1'b0};
			end
			// address and length stay locked while the cipher runs
			if (wr_reg && state_q == ST_IDLE) begin
				case (roff)
					`SRZ_OFF_PT_START: pt_start_q <= PWDATA_IN;
					`SRZ_OFF_CT_START: ct_start_q <= PWDATA_IN;
					`SRZ_OFF_LENGTH: length_q <= PWDATA_IN;
					`SRZ_OFF_IV0: iv0_q <= PWDATA_IN;
					`SRZ_OFF_IV1: iv1_q <= PWDATA_IN;
					default: begin
					end
				endcase
			end
			// error bits: write one clears, a new error wins
			if (wr_reg && roff == `SRZ_OFF_ERR_STAT) begin
				err_q[`SRZ_ERR_TMR_BIT] <= ~PWDATA_IN[`SRZ_ERR_TMR_BIT] & err_q[`SRZ_ERR_TMR_BIT];
				err_q[`SRZ_ERR_START_BIT] <= ~PWDATA_IN[`SRZ_ERR_START_BIT] & err_q[`SRZ_ERR_START_BIT];
			end
			if (tmr_expired) begin
				err_q[`SRZ_ERR_TMR_BIT] <= 1'b1;
			end
			if (start_bad) begin
				err_q[`SRZ_ERR_START_BIT] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status, mask and output
	wire [`SRZ_INT_W-1:0] ev;
	assign ev[`SRZ_INT_ZDONE_BIT] = (state_q == ST_ZERO) & zero_last & ~zero_req;
	assign ev[`SRZ_INT_CIPH_BIT] = (state_q == ST_CIPH) & last_word & zdone_q & ~zero_req;
	assign ev[`SRZ_INT_TMR_BIT] = tmr_expired;
	assign ev[`SRZ_INT_DBG_BIT] = (|DEBUG_IN) & ~(|dbg_q);
	wire clr_int = wr_reg & (roff == `SRZ_OFF_INT_STAT);

	always @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			int_stat_q <= `SRZ_RST_INT;
			int_mask_q <= `SRZ_RST_INT;
			IRQ_OUT <= 1'b0;
		end else begin
			// set wins over the write-one clear of the same cycle
			int_stat_q <= ev | (int_stat_q & ~(clr_int ? PWDATA_IN[`SRZ_INT_W-1:0] : `SRZ_RST_INT));
			if (wr_reg && roff == `SRZ_OFF_INT_MASK) begin
				int_mask_q <= PWDATA_IN[`SRZ_INT_W-1:0];
			end
			IRQ_OUT <= |(int_stat_q & int_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// debug detector and monitor outputs
	always @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			dbg_q <= {DBG_W{1'b0}};
			DBG_ALERT_OUT <= 1'b0;
			TMR_ERR_OUT <= 1'b0;
			ZDONE_OUT <= 1'b0;
		end else begin
			dbg_q <= DEBUG_IN;
			DBG_ALERT_OUT <= |DEBUG_IN;
			TMR_ERR_OUT <= err_q[`SRZ_ERR_TMR_BIT] | tmr_expired;
			ZDONE_OUT <= zdone_q & ~zero_req;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// security timer, reloaded by software as its service
	srz_sec_timer #(
		.TW(32)
	) u_timer (
		.clk_in(SYS_CLK_IN),
		.rst_n_in(RST_N_IN),
		.load_in(wr_reg & (roff == `SRZ_OFF_TMR_LOAD)),
		.load_val_in(PWDATA_IN),
		.count_out(tmr_count),
		.expired_out(tmr_expired)
	);

	////////////////////////////////////////////////////////////////////////
	// read mux; the key has no path here by construction
	always @* begin
		rd_d = 32'h0000_0000;
		err_d = 1'b0;
		if (!host_ok || zero_req) begin
			// a read that meets a starting zeroize is refused too
			rd_d = 32'h0000_0000;
		end else if (is_mem) begin
			if (state_q == ST_IDLE) begin
				rd_d = mem_q[host_idx];
			end
		end else begin
			case (roff)
				`SRZ_OFF_CTRL: rd_d = ctrl_q;
				`SRZ_OFF_PT_START: rd_d = pt_start_q;
				`SRZ_OFF_CT_START: rd_d = ct_start_q;
				`SRZ_OFF_LENGTH: rd_d = length_q;
				`SRZ_OFF_ERR_STAT: rd_d = err_q;
				`SRZ_OFF_IV0: rd_d = iv0_q;
				`SRZ_OFF_IV1: rd_d = iv1_q;
				`SRZ_OFF_ZCTL: rd_d = 32'h0000_0000;
				`SRZ_OFF_STATUS: rd_d = {27'h0, SECURE_IN, state_q, 1'b0, zdone_q};
				`SRZ_OFF_INT_STAT: rd_d = {28'h0, int_stat_q};
				`SRZ_OFF_INT_MASK: rd_d = {28'h0, int_mask_q};
				`SRZ_OFF_TMR_LOAD: rd_d = 32'h0000_0000;
				`SRZ_OFF_TMR_COUNT: rd_d = tmr_count;
				`SRZ_OFF_DBG_STAT: rd_d = {{(32-DBG_W){1'b0}}, dbg_q};
				default: err_d = 1'b1; // unmapped offset
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus answer: no wait state, data captured at the setup edge
	always @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			PREADY_OUT <= 1'b0;
			PRDATA_OUT <= 32'h0000_0000;
			PSLVERR_OUT <= 1'b0;
		end else if (setup) begin
			PREADY_OUT <= 1'b1;
			PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : rd_d;
			PSLVERR_OUT <= err_d;
		end else begin
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT <= 32'h0000_0000;
		end
	end

endmodule

// ==== verif/srz_props.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// watches bus answers, zeroize progress and monitor outputs
module srz_props (
	input wire SYS_CLK_IN,
	input wire RST_N_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [31:0] PRDATA_OUT,
	input wire PREADY_OUT,
	input wire PSLVERR_OUT,
	input wire ZEROIZE_IN,
	input wire VIOLATION_IN,
	input wire [31:0] SECRET_KEY_IN,
	input wire [3:0] DEBUG_IN,
	input wire ZDONE_OUT,
	input wire DBG_ALERT_OUT,
	input wire TMR_ERR_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// low-time counter of zeroize done, reset included on purpose
	logic [10:0] lo_q = 11'h0;
	always @(posedge SYS_CLK_IN) begin
		if (ZDONE_OUT)
			lo_q <= 11'h0;
		else if (lo_q != 11'h7ff)
			lo_q <= lo_q + 11'h1;
	end
	wire zap = ZEROIZE_IN || VIOLATION_IN || PSEL_IN;
	property p_rdy; PSEL_IN && !PENABLE_IN |=> PREADY_OUT; endproperty
	a_rdy: assert property (p_rdy) else $error("no answer after setup");
	property p_rdy1; PREADY_OUT |=> !PREADY_OUT; endproperty
	a_rdy1: assert property (p_rdy1) else $error("answer longer than one cycle");
	property p_idle; !PREADY_OUT |-> PRDATA_OUT == 32'h0 && !PSLVERR_OUT; endproperty
	a_idle: assert property (p_idle) else $error("read bus not quiet");
	property p_nozd; PREADY_OUT && !ZDONE_OUT |-> PRDATA_OUT == 32'h0 && !PSLVERR_OUT; endproperty
	a_nozd: assert property (p_nozd) else $error("access served during zeroize");
	property p_key; PREADY_OUT |-> PRDATA_OUT != SECRET_KEY_IN; endproperty
	a_key: assert property (p_key) else $error("key seen on bus");
	property p_zfall; ZEROIZE_IN || VIOLATION_IN |=> ##1 !ZDONE_OUT; endproperty
	a_zfall: assert property (p_zfall) else $error("done stayed high");
	property p_zlen; $rose(ZDONE_OUT) |-> lo_q >= 11'd510; endproperty
	a_zlen: assert property (p_zlen) else $error("zeroize too short");
	property p_dbg; RST_N_IN |=> DBG_ALERT_OUT == |$past(DEBUG_IN); endproperty
	a_dbg: assert property (p_dbg) else $error("debug alert wrong");
	property p_tmr; TMR_ERR_OUT && !zap && !$past(zap) |=> TMR_ERR_OUT; endproperty
	a_tmr: assert property (p_tmr) else $error("timer error dropped");
endmodule
////////////////////////////////////////////////////////////
bind srz_top srz_props u_props (.SYS_CLK_IN, .RST_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PRDATA_OUT,
	.PREADY_OUT, .PSLVERR_OUT, .ZEROIZE_IN, .VIOLATION_IN, .SECRET_KEY_IN, .DEBUG_IN, .ZDONE_OUT,
	.DBG_ALERT_OUT, .TMR_ERR_OUT);

// ==== verif/srz_host.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// host processor: one bus transfer at a time, released lines flip
module srz_host (
	input wire clk_in,
	input wire rdy_in,
	input wire err_in,
	input wire [31:0] rdata_in,
	output logic sel_out = 1'b0,
	output logic en_out = 1'b0,
	output logic wr_out = 1'b0,
	output logic [11:0] addr_out = 12'h0,
	output logic [31:0] data_out = 32'h0
);
	// call right after a rising edge; ends one edge after release
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e, output logic to);
		int n;
		n = 0;
		sel_out <= 1'b1;
		en_out <= 1'b0;
		wr_out <= w;
		addr_out <= a;
		data_out <= d;
		@(posedge clk_in);
		en_out <= 1'b1;
		// bounded wait so a dead slave cannot hang the run
		do begin
			@(posedge clk_in);
			n++;
		end while (!rdy_in && n < 40);
		q = rdata_in;
		e = err_in;
		to = !rdy_in;
		sel_out <= 1'b0;
		en_out <= 1'b0;
		addr_out <= ~a;
		data_out <= ~d;
		@(posedge clk_in);
	endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
module tb;
	localparam [31:0] DKEY = 32'h0f1e2d3c; // arbitrary default key
	logic clk = 1'b0, rst_n = 1'b0, zer = 1'b0, vio = 1'b0, sec = 1'b0;
	logic sel, en, wr, rdy, err, irq, zd, dal, ter, e, to;
	logic [11:0] addr;
	logic [31:0] wd, rd, q, iv0, iv1, prev, c;
	logic [31:0] key = 32'h6c3b9e01;
	logic [31:0] seed = 32'h2e18a67d;
	logic [3:0] dbg = 4'h0;
	logic [3:0] dprev = 4'h0; // debug lines before the last change
	logic rise = 1'b0; // a debug rise is expected in the status
	logic [31:0] mem_m [512]; // bench memory model
	int iq[$];
	int err_total = 0, num_checks = 0, n;
	srz_top #(.DEFAULT_KEY(DKEY)) u_dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(sel), .PENABLE_IN(en),
		.PWRITE_IN(wr), .PADDR_IN(addr), .PWDATA_IN(wd), .PRDATA_OUT(rd), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
		.ZEROIZE_IN(zer), .VIOLATION_IN(vio), .SECURE_IN(sec), .SECRET_KEY_IN(key), .DEBUG_IN(dbg),
		.IRQ_OUT(irq), .ZDONE_OUT(zd), .DBG_ALERT_OUT(dal), .TMR_ERR_OUT(ter));
	srz_host u_host (.clk_in(clk), .rdy_in(rdy), .err_in(err), .rdata_in(rd), .sel_out(sel), .en_out(en),
		.wr_out(wr), .addr_out(addr), .data_out(wd));
	initial begin
		forever #10 clk = ~clk;
	end
	// hang guard well above the expected run length
	initial begin
		#1000000;
		err_total++;
		results();
	end
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task results;
		if (err_total == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// a spent wait bound counts as a mismatch and ends the run
	task give_up(input logic hit);
		if (hit) begin
			err_total++;
			results();
		end
	endtask
	task rw(input logic w, input logic [11:0] a, input logic [31:0] d);
		u_host.xfer(w, a, d, q, e, to);
		give_up(to);
	endtask
	// polls the status register until the memory is idle again
	task poll_idle;
		n = 0;
		do begin
			rw(1'b0, 12'h020, 32'h0);
			n++;
		end while (q[3:2] != 2'b00 && n < 30);
		give_up(q[3:2] != 2'b00);
	endtask
	task rd_chk(input logic [11:0] a, input logic [31:0] x);
		rw(1'b0, a, 32'h0);
		chk(q, x);
		chk({31'h0, e}, 32'h0);
	endtask
	// waits for zeroize done; n is the cycles spent
	task wait_zd;
		n = 0;
		while (zd !== 1'b1 && n < 1200) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, zd}, 32'h1);
		give_up(zd !== 1'b1);
	endtask
	task zap(input int m);
		if (m == 0)
			rw(1'b1, 12'h01c, 32'h1);
		else begin
			zer <= (m == 1);
			vio <= (m == 2);
			@(posedge clk);
			zer <= 1'b0;
			vio <= 1'b0;
		end
		repeat (2) @(posedge clk);
		chk({31'h0, zd}, 32'h0);
		wait_zd();
		chk(n >= 500, 1);
	endtask
	initial begin
		foreach (mem_m[i]) mem_m[i] = 32'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		// accesses during the reset zeroize go nowhere
		rw(1'b1, 12'h800, 32'h1);
		rd_chk(12'h800, 32'h0);
		wait_zd();
		for (int i = 0; i < 8; i++) rd_chk(12'(i * 4), 32'h0);
		rd_chk(12'h020, 32'h1);
		rw(1'b0, 12'h038, 32'h0);
		chk({31'h0, e}, 32'h1);
		// random words, top word included
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			iq.push_back(i == 0 ? 511 : 24 + seed[7:0]);
			mem_m[iq[i]] = seed;
			rw(1'b1, 12'h800 + 12'(iq[i] * 4), seed);
		end
		foreach (iq[i]) rd_chk(12'h800 + 12'(iq[i] * 4), mem_m[iq[i]]);
		// encrypt with default key, then with the secret key
		for (int s = 0; s < 2; s++) begin
			sec <= s[0];
			iv0 = lfsr(seed);
			iv1 = lfsr(iv0);
			seed = iv1;
			for (int j = 0; j < 8; j++) begin
				seed = lfsr(seed);
				mem_m[j] = seed;
				rw(1'b1, 12'h800 + 12'(j * 4), seed);
			end
			rw(1'b1, 12'h004, 32'h0);
			rw(1'b1, 12'h008, 32'h10);
			rw(1'b1, 12'h00c, 32'h8);
			rw(1'b1, 12'h014, iv0);
			rw(1'b1, 12'h018, iv1);
			rw(1'b1, 12'h000, 32'h1);
			rd_chk(12'h800, 32'h0);
			poll_idle();
			chk(q, {27'h0, s[0], 4'h1});
			prev = iv0;
			for (int j = 0; j < 8; j++) begin
				c = mem_m[j] ^ (s ? key : DKEY) ^ iv1 ^ prev;
				mem_m[16 + j] = c;
				prev = c;
				rd_chk(12'h840 + 12'(j * 4), c);
			end
		end
		// decrypt the secret-key ciphertext back into words 32 to 39
		rw(1'b1, 12'h004, 32'h20);
		rw(1'b1, 12'h000, 32'h3);
		poll_idle();
		chk(q, 32'h11);
		rd_chk(12'h000, 32'h2);
		for (int j = 0; j < 8; j++) rd_chk(12'h880 + 12'(j * 4), mem_m[j]);
		rw(1'b1, 12'h00c, 32'h0);
		rw(1'b1, 12'h000, 32'h1);
		rd_chk(12'h010, 32'h2);
		// zeroize by register bit, by pin, by violation
		for (int m = 0; m < 3; m++) begin
			rw(1'b1, 12'h814, 32'ha5);
			rw(1'b1, 12'h00c, 32'h3);
			zap(m);
			rd_chk(12'h814, 32'h0);
			rd_chk(12'h00c, 32'h0);
		end
		rd_chk(12'h024, 32'h3);
		rw(1'b1, 12'h028, 32'h1);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1);
		rw(1'b1, 12'h024, 32'hf);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		// watchdog left to run out
		rw(1'b1, 12'h02c, 32'h14);
		n = 0;
		while (ter !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk(n >= 16 && n <= 21, 1);
		give_up(ter !== 1'b1);
		rd_chk(12'h010, 32'h1);
		rd_chk(12'h024, 32'h4);
		rw(1'b1, 12'h024, 32'hf);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			dbg <= seed[3:0];
			rise = rise | ((|seed[3:0]) & ~(|dprev));
			dprev = seed[3:0];
			repeat (2) @(posedge clk);
			chk({31'h0, dal}, {31'h0, |seed[3:0]});
			rd_chk(12'h034, {28'h0, seed[3:0]});
		end
		rd_chk(12'h024, {28'h0, rise, 3'b000});
		results();
	end
endmodule
